// ### rtl/rst_gen_pkg.sv
`default_nettype none
package rst_gen_pkg;
  localparam int unsigned CLK_RATE_KHZ     = 50_000;
  localparam int unsigned STRETCH_TIME_US  = 1000;
  localparam int unsigned STRETCH_CYCLES   = (STRETCH_TIME_US * CLK_RATE_KHZ + 999) / 1000;
  localparam int unsigned WDT_RST_CYCLES   = 4;
  localparam int unsigned PIN_MASK_CYCLES  = 4;
  localparam int unsigned STRETCH_W        = 16;

  localparam logic [3:0] OFS_CTRL          = 4'h0;
  localparam logic [3:0] OFS_STATUS        = 4'h4;
  localparam logic [3:0] OFS_WDT_COUNT     = 4'h8;

  localparam int unsigned CTRL_RELEASE_BIT = 0;
  localparam int unsigned CTRL_GPIO_BIT    = 1;
  localparam int unsigned CTRL_SRCSEL_BIT  = 2;
  localparam logic        CTRL_RELEASE_RST = 1'b0;
  localparam logic        CTRL_GPIO_RST    = 1'b0;
  localparam logic        CTRL_SRCSEL_RST  = 1'b0;

  localparam int unsigned ST_WDT_FLAG_BIT  = 0;
  localparam int unsigned ST_SUPPLY_BIT    = 1;
  localparam int unsigned ST_MAIN_RST_BIT  = 2;
  localparam int unsigned ST_IO_RST_N_BIT  = 3;
  localparam int unsigned ST_PROC_RST_BIT  = 4;
  localparam int unsigned ST_SRC_LSB       = 5;

  localparam logic [7:0]  WDT_COUNT_RST    = 8'h00;

  typedef enum logic [1:0] {
    SRC_RING,
    SRC_SUSPEND,
    SRC_CRYSTAL
  } clk_src_e;
endpackage
`default_nettype wire

// ### rtl/chip_reset_generation.sv
// Contract
// - Battery reset pulse on supply rise, battery low
// - Cell replaced while supply low holds reset
// - No battery action while supply good
// - Battery reset clears battery-well registers
// - Main reset follows supply-good low
// - Main reset pin input asserts main reset
// - Watchdog reset asserts main reset
// - Main reset clears main-well registers
// - IO reset on supply, power-good, host reset
// - Software release bit gates IO reset release
// - Watchdog reset asserts IO reset
// - Watchdog keeps the event count register
// - Watchdog never clears battery-well state
// - No pin glitch drive on watchdog reset
// - Watchdog event sets reset and status flag
// - Processor reset stretched after main reset
// - Host reset pin as GPIO forced low
// - Slow clock falls back to ring oscillator
// - Select bit chooses suspend input or crystal
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module chip_reset_generation #(
  parameter int unsigned STRETCH_LEN = rst_gen_pkg::STRETCH_CYCLES
) (
  input  wire logic        clk,                      // 50 MHz clock
  input  wire logic        sys_rst,                  // Synchronous reset
  input  wire logic [3:0]  reg_addr,                 // Register byte address
  input  wire logic [31:0] reg_wdata,                // Write data
  input  wire logic        reg_wr,                   // Write strobe
  input  wire logic        reg_rd,                   // Read strobe
  output logic      [31:0] reg_rdata,                // Read data, cycle after strobe
  input  wire logic        main_supply_good,         // Supply monitor, pin
  input  wire logic        battery_good,             // Battery above threshold, pin
  input  wire logic        platform_power_good,      // Platform power-good, pin
  input  wire logic        host_bus_reset_pin,       // Host bus reset, active low
  input  wire logic        main_reset_pin_in,        // Open-drain reset pin level
  output logic             main_reset_pin_out,       // Pin drive value
  output logic             main_reset_pin_oe,        // Pin drive enable
  input  wire logic        watchdog_event,           // Watchdog expiry pulse
  input  wire logic        suspend_clock_input,      // Suspend clock valid, pin
  input  wire logic        crystal_ok,               // Crystal running, pin
  output logic             battery_por,              // Battery-well reset
  output logic             main_domain_reset,        // Main-well reset
  output logic             system_io_reset_n,        // System IO reset, active low
  output logic             watchdog_reset,           // Watchdog reset
  output logic             core_processor_reset,     // Stretched processor reset
  output rst_gen_pkg::clk_src_e slow_clock_domain    // Slow clock source chosen
);
  import rst_gen_pkg::*;

  localparam int unsigned NSYNC = 7;
  localparam int unsigned I_SUP = 0;
  localparam int unsigned I_BAT = 1;
  localparam int unsigned I_PGD = 2;
  localparam int unsigned I_HBR = 3;
  localparam int unsigned I_PIN = 4;
  localparam int unsigned I_SUS = 5;
  localparam int unsigned I_XTL = 6;
  localparam logic [STRETCH_W-1:0] STRETCH_LOAD =
    STRETCH_W'(STRETCH_LEN - 1);
  localparam logic [2:0] WDT_LOAD  = 3'(WDT_RST_CYCLES);
  localparam logic [2:0] MASK_LOAD = 3'(PIN_MASK_CYCLES);

  logic [NSYNC-1:0]     sync1_reg;
  logic [NSYNC-1:0]     sync2_reg;
  logic                 supply_s;
  logic                 battery_s;
  logic                 pgood_s;
  logic                 host_rst_s;
  logic                 pin_s;
  logic                 supply_prev_reg;
  logic                 battery_prev_reg;
  logic                 supply_rise;
  logic                 cell_insert_hold_reg;
  logic                 battery_por_reg;
  logic                 battery_rst;
  logic [2:0]           wdt_cnt_reg;
  logic                 wdt_active;
  logic                 watchdog_reset_reg;
  logic                 wdt_origin_reg;
  logic [7:0]           wdt_count_reg;
  logic                 watchdog_event_flag_reg;
  logic                 main_reset_reg;
  logic                 main_rst;
  logic [2:0]           pin_mask_reg;
  logic                 pin_masked;
  logic                 pin_reset_req;
  logic                 pin_oe_reg;
  logic [STRETCH_W-1:0] stretch_cnt_reg;
  logic                 proc_reset_reg;
  logic                 io_reset_n_reg;
  logic                 host_rst_eff;
  logic                 io_reset_release_ctl_reg;
  logic                 host_pin_gpio_reg;
  logic                 slow_clock_source_sel_reg;
  clk_src_e             slow_src_reg;
  logic [31:0]          rdata_reg;
  logic                 wr_ctrl;
  logic                 wr_status;
  logic                 flag_clear;

  // Chooses the slow clock source from selection and availability
  function automatic clk_src_e pick_source(
    input logic sel_crystal,
    input logic sus_ok,
    input logic xtl_ok
  );
    clk_src_e src;
    src = SRC_RING;
    if (sel_crystal) begin
      if (xtl_ok) begin
        src = SRC_CRYSTAL;
      end
    end else if (sus_ok) begin
      src = SRC_SUSPEND;
    end
    return src;
  endfunction

  // Both edges of every pin input are synchronised before use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {crystal_ok, suspend_clock_input, main_reset_pin_in,
                    host_bus_reset_pin, platform_power_good, battery_good,
                    main_supply_good};
      sync2_reg <= sync1_reg;
    end
  end

  assign supply_s   = sync2_reg[I_SUP];
  assign battery_s  = sync2_reg[I_BAT];
  assign pgood_s    = sync2_reg[I_PGD];
  assign host_rst_s = sync2_reg[I_HBR];
  assign pin_s      = sync2_reg[I_PIN];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_prev_reg  <= 1'b0;
      battery_prev_reg <= 1'b0;
    end else begin
      supply_prev_reg  <= supply_s;
      battery_prev_reg <= battery_s;
    end
  end

  assign supply_rise = supply_s & ~supply_prev_reg;

  // Cell inserted while supply is down: hold until supply returns
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cell_insert_hold_reg <= 1'b0;
    end else if (supply_s) begin
      cell_insert_hold_reg <= 1'b0;
    end else if (battery_s & ~battery_prev_reg) begin
      cell_insert_hold_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      battery_por_reg <= 1'b0;
    end else begin
      battery_por_reg <= (supply_rise & ~battery_s)
                       | (~supply_s & cell_insert_hold_reg);
    end
  end

  assign battery_rst = sys_rst | battery_por_reg;

  // Watchdog reset lasts a fixed number of cycles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_cnt_reg <= '0;
    end else if (watchdog_event) begin
      wdt_cnt_reg <= WDT_LOAD;
    end else if (wdt_cnt_reg != '0) begin
      wdt_cnt_reg <= wdt_cnt_reg - 3'h1;
    end
  end

  assign wdt_active = watchdog_event | (wdt_cnt_reg != '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_reset_reg <= 1'b0;
    end else begin
      watchdog_reset_reg <= wdt_active;
    end
  end

  // Event count survives watchdog resets, cleared only by supply loss or sys_rst
  always_ff @(posedge clk) begin
    if (sys_rst | ~supply_s) begin
      wdt_count_reg <= WDT_COUNT_RST;
    end else if (watchdog_event) begin
      wdt_count_reg <= wdt_count_reg + 8'h01;
    end
  end

  assign wr_ctrl    = reg_wr & (reg_addr == OFS_CTRL);
  assign wr_status  = reg_wr & (reg_addr == OFS_STATUS);
  assign flag_clear = wr_status & reg_wdata[ST_WDT_FLAG_BIT];

  // Battery-well flag: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (battery_rst) begin
      watchdog_event_flag_reg <= 1'b0;
    end else if (watchdog_event) begin
      watchdog_event_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      watchdog_event_flag_reg <= 1'b0;
    end
  end

  // Pin input is ignored while driven and a few cycles after release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_mask_reg <= MASK_LOAD;
    end else if (pin_oe_reg) begin
      pin_mask_reg <= MASK_LOAD;
    end else if (pin_mask_reg != '0) begin
      pin_mask_reg <= pin_mask_reg - 3'h1;
    end
  end

  assign pin_masked    = pin_oe_reg | (pin_mask_reg != '0);
  assign pin_reset_req = ~pin_s & ~pin_masked;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_reset_reg <= 1'b1;
    end else begin
      main_reset_reg <= ~supply_s
                      | pin_reset_req
                      | wdt_active;
    end
  end

  assign main_rst = sys_rst | main_reset_reg;

  // Remembers whether the current reset came only from the watchdog
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_origin_reg <= 1'b0;
    end else if (~supply_s | pin_reset_req) begin
      wdt_origin_reg <= 1'b0;
    end else if (watchdog_event) begin
      wdt_origin_reg <= 1'b1;
    end else if (~proc_reset_reg & ~main_reset_reg) begin
      wdt_origin_reg <= 1'b0;
    end
  end

  // Processor reset stretch, restarted by every main reset cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stretch_cnt_reg <= STRETCH_LOAD;
    end else if (main_reset_reg) begin
      stretch_cnt_reg <= STRETCH_LOAD;
    end else if (stretch_cnt_reg != '0) begin
      stretch_cnt_reg <= stretch_cnt_reg - STRETCH_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      proc_reset_reg <= 1'b1;
    end else begin
      proc_reset_reg <= main_reset_reg | (stretch_cnt_reg != '0);
    end
  end

  // Pin is pulled low during the stretch, except for watchdog resets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_oe_reg <= 1'b1;
    end else begin
      pin_oe_reg <= (main_reset_reg | (stretch_cnt_reg != '0))
                  & ~(wdt_origin_reg | watchdog_event);
    end
  end

  assign host_rst_eff = host_pin_gpio_reg ? 1'b0 : host_rst_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_reset_n_reg <= 1'b0;
    end else begin
      io_reset_n_reg <= supply_s & pgood_s & host_rst_eff
                      & io_reset_release_ctl_reg
                      & ~wdt_active & ~main_reset_reg;
    end
  end

  // Main-well control bits
  always_ff @(posedge clk) begin
    if (main_rst) begin
      io_reset_release_ctl_reg <= CTRL_RELEASE_RST;
      host_pin_gpio_reg        <= CTRL_GPIO_RST;
    end else if (wr_ctrl) begin
      io_reset_release_ctl_reg <= reg_wdata[CTRL_RELEASE_BIT];
      host_pin_gpio_reg        <= reg_wdata[CTRL_GPIO_BIT];
    end
  end

  // Battery-well source select, untouched by main or watchdog resets
  always_ff @(posedge clk) begin
    if (battery_rst) begin
      slow_clock_source_sel_reg <= CTRL_SRCSEL_RST;
    end else if (wr_ctrl) begin
      slow_clock_source_sel_reg <= reg_wdata[CTRL_SRCSEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slow_src_reg <= SRC_RING;
    end else begin
      slow_src_reg <= pick_source(slow_clock_source_sel_reg,
                                  sync2_reg[I_SUS],
                                  sync2_reg[I_XTL]);
    end
  end

  // Register read port, data valid one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= 32'h0000_0000;
      case (reg_addr)
        OFS_CTRL: begin
          rdata_reg[CTRL_RELEASE_BIT] <= io_reset_release_ctl_reg;
          rdata_reg[CTRL_GPIO_BIT]    <= host_pin_gpio_reg;
          rdata_reg[CTRL_SRCSEL_BIT]  <= slow_clock_source_sel_reg;
        end
        OFS_STATUS: begin
          rdata_reg[ST_WDT_FLAG_BIT] <= watchdog_event_flag_reg;
          rdata_reg[ST_SUPPLY_BIT]   <= supply_s;
          rdata_reg[ST_MAIN_RST_BIT] <= main_reset_reg;
          rdata_reg[ST_IO_RST_N_BIT] <= io_reset_n_reg;
          rdata_reg[ST_PROC_RST_BIT] <= proc_reset_reg;
          rdata_reg[ST_SRC_LSB+1:ST_SRC_LSB] <= slow_src_reg;
        end
        OFS_WDT_COUNT: begin
          rdata_reg[7:0] <= wdt_count_reg;
        end
        default: begin
          rdata_reg <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata            = rdata_reg;
  assign battery_por          = battery_por_reg;
  assign main_domain_reset    = main_reset_reg;
  assign system_io_reset_n    = io_reset_n_reg;
  assign watchdog_reset       = watchdog_reset_reg;
  assign core_processor_reset = proc_reset_reg;
  assign main_reset_pin_out   = 1'b0;
  assign main_reset_pin_oe    = pin_oe_reg;
  assign slow_clock_domain    = slow_src_reg;
endmodule // chip_reset_generation
`default_nettype wire

// ### tb/chip_reset_generation_chk.sv
`timescale 1ns/100ps
`default_nettype none
module chip_reset_generation_chk #(
  parameter int unsigned STRETCH_LEN = 20
) (
  input wire logic clk,                  // Clock
  input wire logic sys_rst,              // Reset
  input wire logic main_supply_good,     // Supply pin
  input wire logic battery_good,         // Battery pin
  input wire logic platform_power_good,  // Power-good pin
  input wire logic host_bus_reset_pin,   // Host reset pin
  input wire logic watchdog_event,       // Watchdog pulse
  input wire logic main_reset_pin_oe,    // Pin drive
  input wire logic battery_por,          // Battery reset
  input wire logic main_domain_reset,    // Main reset
  input wire logic system_io_reset_n,    // IO reset
  input wire logic watchdog_reset,       // Watchdog reset
  input wire logic core_processor_reset  // Processor reset
);
  int unsigned since_drop;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Cycles since the main reset last fell
  always_ff @(posedge clk) begin
    if (sys_rst || main_domain_reset) begin
      since_drop <= 0;
    end else if (since_drop < 100_000) begin
      since_drop <= since_drop + 1;
    end
  end
  a_battery_pulse_once: assert property ($rose(battery_por) && main_supply_good |=> !battery_por)
    else $error("battery reset pulse too long");
  a_battery_level_hold: assert property (
    !main_supply_good[*4] ##0 $rose(battery_good) |-> ##[1:4] battery_por)
    else $error("battery reset missing after cell swap");
  a_battery_quiet_good: assert property (main_supply_good[*8] |-> !battery_por)
    else $error("battery reset while supply good");
  a_main_follows_supply: assert property (!main_supply_good[*3] |=> main_domain_reset)
    else $error("main reset missing with supply low");
  a_watchdog_main_rst: assert property (watchdog_event |=> main_domain_reset && watchdog_reset)
    else $error("watchdog did not reset main domain");
  a_watchdog_io_rst: assert property (watchdog_event |=> !system_io_reset_n)
    else $error("watchdog did not reset io");
  a_watchdog_no_pin: assert property (
    watchdog_event && !main_reset_pin_oe && !main_domain_reset && main_supply_good |=> !main_reset_pin_oe)
    else $error("pin driven on watchdog reset");
  a_io_rst_causes: assert property (
    (!main_supply_good || !platform_power_good || !host_bus_reset_pin)[*3] |=> !system_io_reset_n)
    else $error("io reset not asserted");
  a_io_release_gate: assert property (
    $rose(system_io_reset_n) |-> platform_power_good && host_bus_reset_pin && !main_domain_reset)
    else $error("io reset released with cause present");
  a_proc_with_main: assert property (main_domain_reset |=> core_processor_reset)
    else $error("processor reset not with main reset");
  a_proc_stretch_len: assert property (
    $fell(core_processor_reset) |-> since_drop >= STRETCH_LEN - 1 && since_drop <= STRETCH_LEN + 1)
    else $error("processor reset stretch wrong");
endmodule // chip_reset_generation_chk

bind chip_reset_generation chip_reset_generation_chk #(
  .STRETCH_LEN(STRETCH_LEN)
) i_chk (
  .clk                  (clk),
  .sys_rst              (sys_rst),
  .main_supply_good     (main_supply_good),
  .battery_good         (battery_good),
  .platform_power_good  (platform_power_good),
  .host_bus_reset_pin   (host_bus_reset_pin),
  .watchdog_event       (watchdog_event),
  .main_reset_pin_oe    (main_reset_pin_oe),
  .battery_por          (battery_por),
  .main_domain_reset    (main_domain_reset),
  .system_io_reset_n    (system_io_reset_n),
  .watchdog_reset       (watchdog_reset),
  .core_processor_reset (core_processor_reset)
);
`default_nettype wire

// ### tb/board_reset_partner.sv
`timescale 1ns/100ps
`default_nettype none
module board_reset_partner (
  input  wire logic oe,       // Device drives pin
  input  wire logic drv_out,  // Device drive value
  input  wire logic ext_low,  // Board pulls pin low
  output logic      pin       // Resolved pin level
);
  // Open drain with pull-up: any low driver wins
  assign pin = !(oe && !drv_out) && !ext_low;
endmodule // board_reset_partner
`default_nettype wire

// ### tb/chip_reset_generation_tb.sv
`timescale 1ns/100ps
`default_nettype none
module chip_reset_generation_tb;
  import rst_gen_pkg::*;
  typedef struct packed {
    logic     pg;
    logic     host;
    logic     gpio;
    logic     sel;
    logic     sus;
    logic     xtl;
    logic     io;
    clk_src_e src;
  } row_s;
  row_s rows [5] = '{
    '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, SRC_SUSPEND},
    '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, SRC_RING},
    '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, SRC_CRYSTAL},
    '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, SRC_RING},
    '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, SRC_CRYSTAL}};
  logic        clk, sys_rst, reg_wr, reg_rd, sup, bat, pg, host, wde, sus, xtl, ext_low, pin;
  logic        pin_out, pin_oe, bpor, mrst, io_n, wrst, prst;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, rdata, v;
  clk_src_e    src;
  int          fail_count, tests_run, n;

  chip_reset_generation #(.STRETCH_LEN(20)) i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .main_supply_good(sup),
    .battery_good(bat), .platform_power_good(pg), .host_bus_reset_pin(host), .main_reset_pin_in(pin),
    .main_reset_pin_out(pin_out), .main_reset_pin_oe(pin_oe), .watchdog_event(wde),
    .suspend_clock_input(sus), .crystal_ok(xtl), .battery_por(bpor), .main_domain_reset(mrst),
    .system_io_reset_n(io_n), .watchdog_reset(wrst), .core_processor_reset(prst), .slow_clock_domain(src));
  board_reset_partner i_board (.oe(pin_oe), .drv_out(pin_out), .ext_low(ext_low), .pin(pin));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    w(3000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {sys_rst, sup, bat, pg, host, sus, xtl} = 7'h7f;
    {reg_wr, reg_rd, wde, ext_low} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    w(3);
    sys_rst <= 1'h0;
    w(40);
    #1 chk("main_rst", mrst, 1'h0);
    chk("proc_rst", prst, 1'h0);
    chk("io_rst_n", io_n, 1'h0);
    foreach (rows[i]) begin
      wr(OFS_CTRL, {29'h0, rows[i].sel, rows[i].gpio, 1'h1});
      {pg, host, sus, xtl} <= {rows[i].pg, rows[i].host, rows[i].sus, rows[i].xtl};
      w(6);
      #1 chk("io_rst_n", io_n, rows[i].io);
      chk("clk_src", src, rows[i].src);
    end
    rd(OFS_WDT_COUNT);
    chk("wdt_count", v, 1'h0);
    @(posedge clk) wde <= 1'h1;
    @(posedge clk) wde <= 1'h0;
    #1 chk("wdt_rst", wrst, 1'h1);
    chk("main_rst", mrst, 1'h1);
    chk("io_rst_n", io_n, 1'h0);
    chk("pin_oe", pin_oe, 1'h0);
    w(WDT_RST_CYCLES);
    #1 chk("wdt_rst", wrst, 1'h1);
    w(1);
    #1 chk("wdt_rst", wrst, 1'h0);
    chk("pin_oe", pin_oe, 1'h0);
    w(40);
    #1 chk("bat_por", bpor, 1'h0);
    rd(OFS_WDT_COUNT);
    chk("wdt_count", v, 1'h1);
    rd(OFS_STATUS);
    chk("wdt_flag", v & 32'h0000_0001, 1'h1);
    rd(OFS_CTRL);
    chk("ctrl", v, 3'h4);
    wr(OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS);
    chk("wdt_flag", v & 32'h0000_0001, 1'h0);
    rd(4'hc);
    chk("unmapped", v, 1'h0);
    @(posedge clk) ext_low <= 1'h1;
    w(2);
    ext_low <= 1'h0;
    w(1);
    #1 chk("main_rst", mrst, 1'h1);
    w(2);
    #1 chk("pin_oe", pin_oe, 1'h1);
    chk("pin_out", pin_out, 1'h0);
    w(40);
    #1 chk("pin_oe", pin_oe, 1'h0);
    chk("proc_rst", prst, 1'h0);
    wr(OFS_CTRL, 32'h0000_0005);
    bat <= 1'h0;
    w(8);
    #1 chk("bat_por", bpor, 1'h0);
    chk("io_rst_n", io_n, 1'h1);
    @(posedge clk) sup <= 1'h0;
    w(5);
    #1 chk("main_rst", mrst, 1'h1);
    chk("io_rst_n", io_n, 1'h0);
    @(posedge clk) sup <= 1'h1;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      #1 n += bpor;
    end
    chk("bat_pulses", n, 1'h1);
    rd(OFS_CTRL);
    chk("ctrl_src_sel", v & 32'h0000_0004, 1'h0);
    @(posedge clk) sup <= 1'h0;
    w(5);
    bat <= 1'h1;
    w(6);
    #1 chk("bat_por", bpor, 1'h1);
    w(10);
    #1 chk("bat_por", bpor, 1'h1);
    @(posedge clk) sup <= 1'h1;
    sus <= 1'h1;
    w(6);
    #1 chk("bat_por", bpor, 1'h0);
    chk("clk_src", src, SRC_SUSPEND);
    @(posedge clk) sys_rst <= 1'h1;
    w(3);
    #1 chk("main_rst", mrst, 1'h1);
    chk("clk_src", src, SRC_RING);
    @(posedge clk) sys_rst <= 1'h0;
    w(2);
    #1 chk("main_rst", mrst, 1'h1);
    w(38);
    #1 chk("main_rst", mrst, 1'h0);
    chk("proc_rst", prst, 1'h0);
    report_and_stop();
  end
endmodule // chip_reset_generation_tb
`default_nettype wire
